// [src/spu_pkg.sv]
// Shared constants and types of the serial port
package spu_pkg;

	// ----------------------------------------
	// Register indexes, byte address is index times four
	// ----------------------------------------
	localparam logic [7:0] IDX_CONTROL  = 8'h98;
	localparam logic [7:0] IDX_DATA     = 8'h99;
	localparam logic [7:0] IDX_RELOAD_L = 8'hAA;
	localparam logic [7:0] IDX_RELOAD_H = 8'hBA;
	localparam logic [7:0] IDX_BAUD_SEL = 8'hD8;
	localparam logic [7:0] IDX_POWER    = 8'hC0;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] CONTROL_RST  = 8'h00;
	localparam logic [7:0] DATA_RST     = 8'h00;
	localparam logic [7:0] RELOAD_L_RST = 8'hD9;
	localparam logic [7:0] RELOAD_H_RST = 8'h03;
	localparam logic [7:0] BAUD_SEL_RST = 8'h00;
	localparam logic [7:0] POWER_RST    = 8'h00;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTL_MODE_HI  = 7;
	localparam int CTL_MODE_LO  = 6;
	localparam int CTL_MPE      = 5;
	localparam int CTL_REN      = 4;
	localparam int CTL_TB8      = 3;
	localparam int CTL_RB8      = 2;
	localparam int CTL_TI       = 1;
	localparam int CTL_RI       = 0;
	localparam int BAUD_SEL_BIT = 7;
	localparam int DOUBLER_BIT  = 7;
	localparam int RELOAD_W     = 10;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CPU_CLK_HZ   = 100_000_000;
	localparam int MODE0_DIV    = 12;
	localparam int MODE0_HALF   = MODE0_DIV / 2;
	localparam int OVS          = 16;
	localparam logic [3:0] OVS_MID  = 4'h7;
	localparam logic [3:0] OVS_LAST = 4'hF;
	localparam logic [3:0] FRAME8_BITS = 4'hA;
	localparam logic [3:0] FRAME9_BITS = 4'hB;

	typedef enum logic [1:0] {
		MODE_SHIFT  = 2'b00,
		MODE_UART8  = 2'b01,
		MODE_UART9F = 2'b10,
		MODE_UART9V = 2'b11
	} spu_mode_e;

endpackage

// [src/spu_pulse_counter.sv]
// Reloadable up counter that pulses on wrap
`timescale 1ns/1ps
module spu_pulse_counter #(
	parameter int W = 4
) (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         reset_n,
	// Count control
	input  wire logic         countEn,
	input  wire logic [W-1:0] loadVal,
	output logic              wrapPulse
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} spu_cnt_s;

	spu_cnt_s s_q;
	spu_cnt_s s_d;

	if (W < 1) begin : g_chk
		$error("spu_pulse_counter: W must be at least 1");
	end

	// Wraps after 2**W - loadVal counted enables
	assign wrapPulse = countEn && (s_q.cnt == {W{1'b1}});

	always_comb begin
		s_d = s_q;
		if (countEn) begin
			s_d.cnt = wrapPulse ? loadVal : s_q.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

// [src/spu_serial_port.sv]
// Serial port with shift mode and 8/9-bit asynchronous modes, Wishbone slave
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
// What this block does
// - Decode four frame modes, shift at clock/12
// - Mode 2 runs clock/64, or /32 doubled
// - Multiprocessor enable held at control bit 5
// - Receive only while receive enable set
// - Modes 2,3 send tx ninth bit
// - Modes 2,3 capture received ninth bit
// - Transmit done set, never hardware cleared
// - Receive done set at frame end
// - Data write sends, data read returns receive
// - Reload value: low byte plus two bits
// - Baud from reload generator or timer overflow
// - Baud doubler is power register bit 7
// - All timing from processor clock
// - Baud source select only modes 1,3
module spu_serial_port
	import spu_pkg::*;
#(
	parameter int ADR_W = 10
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [ADR_W-1:0] adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// Baud source from timer block
	input  wire logic        timer1Overflow,
	// Serial pins
	input  wire logic        rxdIn,
	output logic             rxdOut,
	output logic             rxdOe,
	output logic             txd
);
	if (ADR_W != 10) begin : g_chk
		$error("spu_serial_port: ADR_W must be 10");
	end

	typedef struct packed {
		logic        ack;
		logic [31:0] datO;
		logic [7:0]  ctl;
		logic [7:0]  rxBuf;
		logic [7:0]  relL;
		logic [7:0]  relH;
		logic [7:0]  baudSel;
		logic [7:0]  power;
		logic        txBusy;
		logic [10:0] txShift;
		logic [3:0]  txBits;
		logic [3:0]  txSub;
		logic        txdLine;
		logic        rxSync1;
		logic        rxSync2;
		logic        rxPrev;
		logic        rxBusy;
		logic [3:0]  rxSub;
		logic [3:0]  rxBits;
		logic [8:0]  rxShift;
		logic        m0Busy;
		logic        m0IsTx;
		logic        m0Phase;
		logic [2:0]  m0Bits;
		logic [7:0]  m0Shift;
		logic        m0Out;
		logic        m0Oe;
	} spu_state_s;

	spu_state_s s_q;
	spu_state_s s_d;

	// ----------------------------------------
	// Baud generation
	// ----------------------------------------
	spu_mode_e        mode;
	logic             isNine;
	logic             doubler;
	logic             useReload;
	logic [9:0]       relValue;
	logic             relPulse;
	logic             m0Pulse;
	logic             basePulse;
	logic [1:0]       tickLoad;
	logic             tick16;

	assign mode      = spu_mode_e'({s_q.ctl[CTL_MODE_HI], s_q.ctl[CTL_MODE_LO]});
	assign isNine    = s_q.ctl[CTL_MODE_HI];
	assign doubler   = s_q.power[DOUBLER_BIT];
	assign useReload = s_q.baudSel[BAUD_SEL_BIT];
	assign relValue  = {s_q.relH[1:0], s_q.relL};

	// Reload generator wraps every 1024 - reload clocks
	spu_pulse_counter #(.W(RELOAD_W)) u_reload (
		.clk_sys   (clk_sys),
		.reset_n   (reset_n),
		.countEn   (1'b1),
		.loadVal   (relValue),
		.wrapPulse (relPulse)
	);

	// Half shift clock, six processor clocks
	spu_pulse_counter #(.W(3)) u_mode0 (
		.clk_sys   (clk_sys),
		.reset_n   (reset_n),
		.countEn   (1'b1),
		.loadVal   (3'(8 - MODE0_HALF)),
		.wrapPulse (m0Pulse)
	);

	// Mode 2 fixed, else source select picks reload or timer
	always_comb begin
		if (mode == MODE_UART9F) begin
			basePulse = 1'b1;
			tickLoad  = doubler ? 2'h2 : 2'h0;
		end else if (useReload) begin
			basePulse = relPulse;
			tickLoad  = doubler ? 2'h2 : 2'h0;
		end else begin
			basePulse = timer1Overflow;
			tickLoad  = doubler ? 2'h3 : 2'h2;
		end
	end

	// Oversample tick, sixteen per bit
	spu_pulse_counter #(.W(2)) u_tick (
		.clk_sys   (clk_sys),
		.reset_n   (reset_n),
		.countEn   (basePulse),
		.loadVal   (tickLoad),
		.wrapPulse (tick16)
	);

	// ----------------------------------------
	// Bus, serial engines
	// ----------------------------------------
	logic [7:0] idx;
	logic       req;
	logic       wrNow;
	logic       startTx;
	logic       setTi;
	logic       setRi;
	logic [7:0] rdVal;

	assign idx   = adr_i[ADR_W-1:2];
	assign req   = cyc_i && stb_i;
	assign wrNow = req && we_i && s_q.ack && sel_i[0];

	always_comb begin
		s_d     = s_q;
		startTx = 1'b0;
		setTi   = 1'b0;
		setRi   = 1'b0;
		rdVal   = 8'h00;
		s_d.ack = req && !s_q.ack;
		case (idx)
			IDX_CONTROL:  rdVal = s_q.ctl;
			IDX_DATA:     rdVal = s_q.rxBuf;
			IDX_RELOAD_L: rdVal = s_q.relL;
			IDX_RELOAD_H: rdVal = s_q.relH;
			IDX_BAUD_SEL: rdVal = s_q.baudSel;
			IDX_POWER:    rdVal = s_q.power;
			default:      rdVal = 8'h00;
		endcase
		if (req && !s_q.ack) begin
			s_d.datO = {24'h000000, rdVal};
		end
		if (wrNow) begin
			case (idx)
				IDX_CONTROL:  s_d.ctl = dat_i[7:0];
				IDX_DATA:     startTx = 1'b1;
				IDX_RELOAD_L: s_d.relL = dat_i[7:0];
				IDX_RELOAD_H: s_d.relH = dat_i[7:0];
				IDX_BAUD_SEL: s_d.baudSel = dat_i[7:0];
				IDX_POWER:    s_d.power = dat_i[7:0];
				default:      s_d.ctl = s_d.ctl;
			endcase
		end

		// Pin synchroniser and edge history
		s_d.rxSync1 = rxdIn;
		s_d.rxSync2 = s_q.rxSync1;
		s_d.rxPrev  = s_q.rxSync2;

		// Asynchronous transmit: start, LSB first, ninth, stop
		if (startTx && mode != MODE_SHIFT) begin
			s_d.txBusy  = 1'b1;
			s_d.txSub   = 4'h0;
			s_d.txShift = isNine ? {1'b1, s_q.ctl[CTL_TB8], dat_i[7:0], 1'b0}
			                     : {2'b11, dat_i[7:0], 1'b0};
			s_d.txBits  = isNine ? FRAME9_BITS : FRAME8_BITS;
		end else if (s_q.txBusy && tick16) begin
			s_d.txSub = s_q.txSub + 4'h1;
			if (s_q.txSub == OVS_LAST) begin
				s_d.txShift = {1'b1, s_q.txShift[10:1]};
				s_d.txBits  = s_q.txBits - 4'h1;
				if (s_q.txBits == 4'h2) begin
					setTi = 1'b1;
				end
				if (s_q.txBits == 4'h1) begin
					s_d.txBusy = 1'b0;
				end
			end
		end

		// Asynchronous receive, start edge then midbit samples
		if (!s_q.rxBusy) begin
			if (s_q.ctl[CTL_REN] && mode != MODE_SHIFT && s_q.rxPrev && !s_q.rxSync2) begin
				s_d.rxBusy = 1'b1;
				s_d.rxSub  = 4'h0;
				s_d.rxBits = 4'h0;
			end
		end else if (tick16) begin
			s_d.rxSub = s_q.rxSub + 4'h1;
			if (s_q.rxSub == OVS_MID) begin
				if (s_q.rxBits == 4'h0) begin
					s_d.rxBusy = !s_q.rxSync2;
					s_d.rxBits = 4'h1;
				end else if (s_q.rxBits <= (isNine ? 4'h9 : 4'h8)) begin
					s_d.rxShift = {s_q.rxSync2, s_q.rxShift[8:1]};
					s_d.rxBits  = s_q.rxBits + 4'h1;
				end else begin
					s_d.rxBusy = 1'b0;
					// Multiprocessor mode drops frames with ninth bit low, or with stop bit low in mode 1
					if (!s_q.ctl[CTL_RI] &&
					    (!s_q.ctl[CTL_MPE] || (isNine ? s_q.rxShift[8] : s_q.rxSync2))) begin
						s_d.rxBuf = isNine ? s_q.rxShift[7:0] : s_q.rxShift[8:1];
						s_d.ctl[CTL_RB8] = isNine ? s_q.rxShift[8] : s_q.rxSync2;
						setRi = 1'b1;
					end
				end
			end
		end

		// Shift register mode, data on rxd, clock on txd
		if (!s_q.m0Busy) begin
			if (mode == MODE_SHIFT && startTx) begin
				s_d.m0Busy  = 1'b1;
				s_d.m0IsTx  = 1'b1;
				s_d.m0Phase = 1'b0;
				s_d.m0Bits  = 3'h0;
				s_d.m0Shift = dat_i[7:0];
				s_d.m0Out   = dat_i[0];
				s_d.m0Oe    = 1'b1;
			end else if (mode == MODE_SHIFT && s_q.ctl[CTL_REN] && !s_q.ctl[CTL_RI]) begin
				s_d.m0Busy  = 1'b1;
				s_d.m0IsTx  = 1'b0;
				s_d.m0Phase = 1'b0;
				s_d.m0Bits  = 3'h0;
				s_d.m0Oe    = 1'b0;
			end
		end else if (m0Pulse) begin
			s_d.m0Phase = !s_q.m0Phase;
			if (!s_q.m0Phase) begin
				if (!s_q.m0IsTx) begin
					s_d.m0Shift = {s_q.rxSync2, s_q.m0Shift[7:1]};
				end
			end else begin
				s_d.m0Bits = s_q.m0Bits + 3'h1;
				if (s_q.m0Bits == 3'h7) begin
					s_d.m0Busy = 1'b0;
					s_d.m0Oe   = 1'b0;
					s_d.m0Out  = 1'b1;
					if (s_q.m0IsTx) begin
						setTi = 1'b1;
					end else begin
						s_d.rxBuf = s_q.m0Shift;
						setRi = 1'b1;
					end
				end else if (s_q.m0IsTx) begin
					s_d.m0Shift = {1'b0, s_q.m0Shift[7:1]};
					s_d.m0Out   = s_q.m0Shift[1];
				end
			end
		end

		// Hardware set wins over a software clear
		s_d.ctl[CTL_TI] = s_d.ctl[CTL_TI] || setTi;
		s_d.ctl[CTL_RI] = s_d.ctl[CTL_RI] || setRi;

		if (s_d.m0Busy) begin
			s_d.txdLine = s_d.m0Phase;
		end else begin
			s_d.txdLine = s_d.txBusy ? s_d.txShift[0] : 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			s_q         <= '0;
			s_q.ctl     <= CONTROL_RST;
			s_q.rxBuf   <= DATA_RST;
			s_q.relL    <= RELOAD_L_RST;
			s_q.relH    <= RELOAD_H_RST;
			s_q.baudSel <= BAUD_SEL_RST;
			s_q.power   <= POWER_RST;
			s_q.txdLine <= 1'b1;
			s_q.rxSync1 <= 1'b1;
			s_q.rxSync2 <= 1'b1;
			s_q.rxPrev  <= 1'b1;
			s_q.m0Out   <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign dat_o  = s_q.datO;
	assign ack_o  = s_q.ack;
	assign txd    = s_q.txdLine;
	assign rxdOut = s_q.m0Out;
	assign rxdOe  = s_q.m0Oe;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_shift_clock_period: assert property (@(posedge clk_sys) disable iff (!reset_n)
		m0Pulse |=> !m0Pulse [*5] ##1 m0Pulse)
		else $error("shift mode half clock is not six cycles");

	a_mode2_tick_rate: assert property (@(posedge clk_sys) disable iff (!reset_n || cyc_i)
		(tick16 && mode == MODE_UART9F && !doubler) |=> !tick16 [*3] ##1 tick16)
		else $error("mode 2 oversample tick is not every four cycles");

	a_rx_needs_enable: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$rose(s_q.rxBusy) |-> $past(s_q.ctl[CTL_REN]))
		else $error("reception started without receive enable");

	a_tx_ninth_loaded: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(startTx && isNine) |=> (s_q.txShift[9] == $past(s_q.ctl[CTL_TB8])) && !s_q.txdLine)
		else $error("ninth transmit bit not taken from control");

	a_rx_ninth_kept: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(setRi && isNine && mode != MODE_SHIFT) |=> s_q.ctl[CTL_RB8] == $past(s_q.rxShift[8]))
		else $error("ninth receive bit not captured");

	a_ti_at_stop: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(s_q.txBusy && tick16 && s_q.txSub == OVS_LAST && s_q.txBits == 4'h2)
		|=> s_q.ctl[CTL_TI] && s_q.txdLine)
		else $error("transmit done not set at stop bit start");

	a_ti_sticky: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(s_q.ctl[CTL_TI] && !(wrNow && idx == IDX_CONTROL)) |=> s_q.ctl[CTL_TI])
		else $error("transmit done cleared by hardware");

	a_ri_on_done: assert property (@(posedge clk_sys) disable iff (!reset_n)
		setRi |=> s_q.ctl[CTL_RI] && (s_q.rxBuf == $past(s_d.rxBuf)))
		else $error("receive done not set on completion");

	a_data_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(req && !s_q.ack && !we_i && idx == IDX_DATA) |=> ack_o && dat_o[7:0] == $past(s_q.rxBuf))
		else $error("data read does not return receive buffer");
endmodule

// [verif/spu_remote_uart.sv]
// Remote asynchronous serial device on the far side of the link
`timescale 1ns/1ps
module spu_remote_uart (
	// Clock
	input  wire logic clk_sys,
	// Serial link
	input  wire logic txd,
	input  wire logic rxdOut,
	output logic      rxd
);
	initial rxd = 1'b1;

	task automatic waitClk(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic drive(input logic v);
		rxd <= v;
	endtask

	// Shift mode: rxd bits change after clock falls, rxdOut taken at rises
	task automatic shiftXfer(input logic [7:0] dOut, output logic [7:0] dIn);
		int n;
		n = 0;
		dIn = 8'hFF;
		while (txd !== 1'b0 && n < 2000) begin
			@(posedge clk_sys);
			n++;
		end
		for (int i = 0; i < 8; i++) begin
			rxd <= dOut[i];
			while (txd !== 1'b1 && n < 2000) begin
				@(posedge clk_sys);
				n++;
			end
			dIn[i] = rxdOut;
			while (i < 7 && txd !== 1'b0 && n < 2000) begin
				@(posedge clk_sys);
				n++;
			end
		end
		@(posedge clk_sys);
		rxd <= 1'b1;
	endtask

	// Start low, data LSB first, optional ninth, stop high
	task automatic sendFrame(input logic [8:0] d, input int nb, input int bitClk);
		logic [10:0] fr;
		fr = {2'b11, d, 1'b0};
		if (nb == 8)
			fr[9] = 1'b1;
		for (int i = 0; i < nb + 2; i++) begin
			@(posedge clk_sys);
			rxd <= fr[i];
			waitClk(bitClk - 1);
		end
	endtask

	task automatic recvFrame(input int nb, input int bitClk, output logic [8:0] d, output logic ok);
		int n;
		d = 9'h1FF;
		n = 0;
		while (txd !== 1'b0 && n < 5000) begin
			@(posedge clk_sys);
			n++;
		end
		waitClk(bitClk / 2);
		ok = (txd === 1'b0);
		for (int i = 0; i < nb; i++) begin
			waitClk(bitClk);
			d[i] = txd;
		end
		waitClk(bitClk);
		ok = ok && (txd === 1'b1);
	endtask
endmodule

// [verif/tb_spu_serial_port.sv]
// Self-checking bench of the serial port
`timescale 1ns/1ps
module tb_spu_serial_port
	import spu_pkg::*;
;
	logic        clk_sys = 1'b0;
	logic        reset_n = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [9:0]  adr = 10'h000;
	logic [31:0] datW = 32'h0;
	logic [31:0] datR;
	logic        ack;
	logic        timerOvf = 1'b0;
	logic [1:0]  tCnt = 2'h0;
	logic        rxdIn;
	logic        rxdOut;
	logic        rxdOe;
	logic        txd;
	logic [7:0]  lfsr = 8'h3E;
	logic [8:0]  expQ[$];
	int          n_fail = 0;
	int          n_compared = 0;

	always #5 clk_sys = ~clk_sys;

	// Timer overflow pulse every 4 clocks
	always @(posedge clk_sys) begin
		tCnt <= tCnt + 2'h1;
		timerOvf <= (tCnt == 2'h3);
	end

	spu_serial_port u_dut (
		.clk_sys(clk_sys), .reset_n(reset_n), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(4'hF), .dat_i(datW), .dat_o(datR), .ack_o(ack), .timer1Overflow(timerOvf),
		.rxdIn(rxdIn), .rxdOut(rxdOut), .rxdOe(rxdOe), .txd(txd)
	);

	spu_remote_uart u_remote (.clk_sys(clk_sys), .txd(txd), .rxdOut(rxdOut), .rxd(rxdIn));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] lfsrNext(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rdat);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		datW <= {24'h0, wd};
		do begin
			@(posedge clk_sys);
		end while (ack !== 1'b1);
		rdat = datR;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		logic [31:0] x;
		wb(1'b1, idx, v, x);
	endtask

	task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp);
		logic [31:0] x;
		wb(1'b0, idx, 8'h00, x);
		chk(x, {24'h0, exp});
	endtask

	// One shift-mode byte, receive when the enable bit is set
	task automatic runShift(input logic [7:0] ctrl);
		logic [7:0] d;
		logic [7:0] got;
		lfsr = lfsrNext(lfsr);
		d = lfsr;
		u_remote.drive(d[0]);
		wr(IDX_CONTROL, ctrl);
		if (!ctrl[4]) begin
			wr(IDX_DATA, d);
			chk({31'h0, rxdOe}, 32'h1);
		end
		u_remote.shiftXfer(d, got);
		repeat (8) @(posedge clk_sys);
		rdChk(IDX_CONTROL, ctrl | (ctrl[4] ? 8'h01 : 8'h02));
		if (ctrl[4])
			rdChk(IDX_DATA, d);
		else
			chk({24'h0, got}, {24'h0, d});
		chk({31'h0, rxdOe}, 32'h0);
		wr(IDX_CONTROL, 8'h00);
	endtask

	// One frame in either direction with a given baud setup
	task automatic runCase(input logic [7:0] ctrl, input logic [7:0] pwr, input logic [7:0] bsel,
			input logic [9:0] rel, input int bitClk, input bit isRx);
		logic [8:0] d;
		logic [8:0] got;
		logic       ok;
		logic       acc;
		int         nb;
		nb = ctrl[7] ? 9 : 8;
		lfsr = lfsrNext(lfsr);
		d = {lfsr[0], lfsrNext(lfsr)};
		wr(IDX_POWER, pwr);
		wr(IDX_BAUD_SEL, bsel);
		wr(IDX_RELOAD_L, rel[7:0]);
		wr(IDX_RELOAD_H, {6'h00, rel[9:8]});
		rdChk(IDX_RELOAD_L, rel[7:0]);
		wr(IDX_CONTROL, ctrl);
		if (isRx) begin
			if (nb == 8)
				d[8] = 1'b1;
			u_remote.sendFrame(d, nb, bitClk);
			acc = ctrl[4] && (!ctrl[5] || d[8]);
			rdChk(IDX_CONTROL, acc ? (ctrl | 8'h01 | {5'h00, d[8], 2'b00}) : ctrl);
			if (acc)
				rdChk(IDX_DATA, d[7:0]);
		end else begin
			expQ.push_back(d);
			wr(IDX_DATA, d[7:0]);
			u_remote.recvFrame(nb, bitClk, got, ok);
			d = expQ.pop_front();
			chk({31'h0, ok}, 32'h1);
			chk({24'h0, got[7:0]}, {24'h0, d[7:0]});
			if (nb == 9)
				chk({31'h0, got[8]}, {31'h0, ctrl[3]});
			rdChk(IDX_CONTROL, ctrl | 8'h02);
			chk({31'h0, rxdOe}, 32'h0);
		end
		wr(IDX_CONTROL, 8'h00);
	endtask

	task automatic results;
		if (n_fail == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		rdChk(IDX_CONTROL, CONTROL_RST);
		rdChk(IDX_DATA, DATA_RST);
		rdChk(IDX_RELOAD_L, RELOAD_L_RST);
		rdChk(IDX_RELOAD_H, RELOAD_H_RST);
		rdChk(IDX_BAUD_SEL, BAUD_SEL_RST);
		rdChk(IDX_POWER, POWER_RST);
		wr(8'h10, 8'h5A);
		rdChk(8'h10, 8'h00);
		rdChk(IDX_CONTROL, 8'h00);
		runShift(8'h00);
		runShift(8'h10);
		runCase(8'h88, 8'h00, 8'h00, 10'h3FF, 64, 1'b0);
		runCase(8'h80, 8'h80, 8'h00, 10'h3FF, 32, 1'b0);
		runCase(8'hD8, 8'h00, 8'h80, 10'h3FF, 64, 1'b0);
		runCase(8'h50, 8'h80, 8'h80, 10'h3FE, 64, 1'b1);
		runCase(8'h90, 8'h80, 8'h00, 10'h3FF, 32, 1'b1);
		runCase(8'h40, 8'h00, 8'h80, 10'h3FF, 64, 1'b1);
		runCase(8'hD0, 8'h80, 8'h00, 10'h3FF, 64, 1'b1);
		runCase(8'hE0, 8'h00, 8'h00, 10'h3FF, 128, 1'b0);
		runCase(8'hF0, 8'h80, 8'h80, 10'h3FF, 32, 1'b1);
		results();
	end

	initial begin
		#900_000;
		n_fail++;
		results();
	end
endmodule
